/* irq_ctrl_regs.vh */
// Register indices, field positions, reset values and vectors of the interrupt controller
`ifndef IRQ_CTRL_REGS_VH
`define IRQ_CTRL_REGS_VH

// Register indices; byte address on the bus is four times the index
`define IRQ_IDX_EN_PRI 10'h0A8
`define IRQ_IDX_PRIO_LSB 10'h0A9
`define IRQ_IDX_EN_SEC 10'h0B8
`define IRQ_IDX_PRIO_MSB 10'h0B9
`define IRQ_IDX_EN_CNV 10'h09A
`define IRQ_IDX_EN_PWM 10'h09B
`define IRQ_IDX_PEND 10'h0C0
`define IRQ_IDX_STAT 10'h0C1

// Reset values
`define IRQ_RST8 8'h00
`define IRQ_RST_PEND 14'h0000
`define IRQ_RST_ISV 4'h0

// Writable bits; reserved positions stay zero
`define EN_PRI_WMASK 8'hBB
`define PRIO_WMASK 8'h3F
`define EN_SEC_WMASK 8'hBF
`define EN_CNV_WMASK 8'h02
`define EN_PWM_WMASK 8'h80

// Enable register fields
`define EN_PRI_GLOBAL 7
`define EN_PRI_TIMER2 5
`define EN_PRI_UART 4
`define EN_PRI_TIMER1 3
`define EN_PRI_TIMER0 1
`define EN_PRI_EXT 0
`define EN_SEC_RELOAD 7
`define EN_SEC_CMP3 5
`define EN_SEC_CMP2 4
`define EN_SEC_CMP1 3
`define EN_SEC_CMP0 2
`define EN_SEC_SPI 1
`define EN_SEC_TWI 0
`define EN_CNV_ADC 1
`define EN_PWM_PULSE 7

// Flags cleared by hardware when their source is serviced
`define IRQ_AUTO_MASK 14'h15C9
`define IRQ_SRC_TIMER2 11
`define IRQ_FLAG_RELOAD 13

// Service vectors in natural order, source 0 first
`define VEC_EXT 16'h0003
`define VEC_PWM 16'h0083
`define VEC_TWI 16'h0043
`define VEC_TIMER0 16'h000B
`define VEC_ADC 16'h008B
`define VEC_SPI 16'h004B
`define VEC_CMP0 16'h0053
`define VEC_TIMER1 16'h001B
`define VEC_CMP1 16'h005B
`define VEC_UART 16'h0023
`define VEC_CMP2 16'h0063
`define VEC_TIMER2 16'h002B
`define VEC_CMP3 16'h006B

`endif

/* irq_request_flag.v */
// One sticky request flag with set-over-clear priority
`timescale 1ns/100ps

module irq_request_flag #(
   parameter AUTO_CLEAR = 0
) (
   // Clock and reset
   input wire mclk,
   input wire reset,
   // Set and clear strobes
   input wire set_evt,
   input wire sw_clr,
   input wire hw_clr,
   // Flag state
   output wire flag_nxt,
   output reg flag_r
);

   wire clr;

   // Auto-cleared flags ignore firmware clears; firmware flags ignore service
   assign clr = (AUTO_CLEAR != 0) ? hw_clr : sw_clr;
   // Event sets the flag whatever the enables; set beats a same-cycle clear
   assign flag_nxt = set_evt | (flag_r & ~clr);

   always @(posedge mclk) begin
      if (reset) begin
         flag_r <= 1'b0;
      end else begin
         flag_r <= flag_nxt;
      end
   end

endmodule

/* irq_level_arbiter.v */
// Picks the winning request by group level, then natural order
`timescale 1ns/100ps

module irq_level_arbiter (
   // Gated requests, source 0 has highest natural order
   input wire [12:0] req,
   // Group level bits
   input wire [5:0] lvl_lsb,
   input wire [5:0] lvl_msb,
   // Winner
   output reg found,
   output reg [3:0] idx,
   output reg [1:0] level
);

   // Group of each source, source 12 in the top field
   localparam [38:0] GROUP_MAP = {3'h5, 3'h5, 3'h4, 3'h4, 3'h3, 3'h3, 3'h2,
                                  3'h1, 3'h1, 3'h1, 3'h0, 3'h0, 3'h0};

   integer i;
   reg [2:0] grp;
   reg [1:0] lvl;

   // Scanning from the lowest order up with >= lets the higher natural order win ties.
   // Natural order is monotone over groups, so this is the group step and the source step.
   always @* begin
      found = 1'b0;
      idx = 4'h0;
      level = 2'h0;
      grp = 3'h0;
      lvl = 2'h0;
      for (i = 12; i >= 0; i = i - 1) begin
         grp = GROUP_MAP[i*3 +: 3];
         lvl = {lvl_msb[grp], lvl_lsb[grp]};
         if (req[i] && (!found || lvl >= level)) begin
            found = 1'b1;
            idx = i[3:0];
            level = lvl;
         end
      end
   end

endmodule

/* grouped_priority_interrupt_ctrl.v */
// Grouped four-level priority interrupt controller with AHB-Lite registers
//
// Overview of operation
// - Request flag sets on its event regardless of any enable.
// - Service only with own and global enable; vector 0x03 to 0x8B given.
// - Simultaneous requests: higher level first, then higher default order; other waits for completion.
// - Equal level: no new routine until current one completes.
// - Four programmable levels; six groups, one level each.
// - Level = {upper priority bit, lower priority bit} of the group.
// - Level 3 most urgent, level 0 least.
// - Equal levels resolved by fixed natural order.
// - Fixed group membership of the thirteen sources.
// - Higher level preempts lower routine; lower waits for higher to finish.
// - Arbitrate: highest level groups, then highest group, then source.
// - Priority registers: bits 5..0 read-write, reset 0; bits 7,6 read 0.
// - Global enable at bit 7 of first enable register blocks everything.
// - First enable register bit layout; bits 6 and 2 read zero.
// - Natural order and vector per source.
// - Some flags cleared by hardware on service, the rest by firmware.
// - Routine completes only on return-from-interrupt.
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "irq_ctrl_regs.vh"

module grouped_priority_interrupt_ctrl (
   // Clock and reset
   input wire mclk,
   input wire reset,
   // AHB-Lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire [31:0] hrdata,
   output wire hresp,
   // Peripheral event pulses, natural order, source 0 first
   input wire [12:0] src_event,
   input wire timer2_reload_event,
   // Core service handshake
   output wire irq_req,
   output wire [15:0] irq_vector,
   output wire [1:0] irq_level,
   input wire irq_ack,
   input wire reti
);

   // Bus state
   reg wr_pend_r;
   reg [9:0] wr_idx_r;
   reg [31:0] hrdata_r;
   reg hreadyout_r;
   wire addr_phase;
   wire [9:0] rd_idx;
   reg [31:0] rdata_nxt;

   // Register file
   reg [7:0] en_pri_r;
   reg [7:0] en_sec_r;
   reg [7:0] en_cnv_r;
   reg [7:0] en_pwm_r;
   reg [7:0] prio_lsb_r;
   reg [7:0] prio_msb_r;
   wire [7:0] en_pri_nxt;
   wire [7:0] en_sec_nxt;
   wire [7:0] en_cnv_nxt;
   wire [7:0] en_pwm_nxt;
   wire [7:0] prio_lsb_nxt;
   wire [7:0] prio_msb_nxt;
   wire wr_en_pri;
   wire wr_en_sec;
   wire wr_en_cnv;
   wire wr_en_pwm;
   wire wr_prio_lsb;
   wire wr_prio_msb;
   wire wr_pend;

   // Enable bits by function
   wire global_irq_enable;
   wire timer2_irq_enable;
   wire uart_irq_enable;
   wire timer1_irq_enable;
   wire timer0_irq_enable;
   wire ext_line_irq_enable;
   wire timer2_reload_irq_enable;
   wire compare0_irq_enable;
   wire compare1_irq_enable;
   wire compare2_irq_enable;
   wire compare3_irq_enable;
   wire serial_periph_irq_enable;
   wire two_wire_irq_enable;
   wire converter_irq_enable;
   wire pulse_gen_irq_enable;

   // Flags and arbitration
   wire [13:0] flag_r;
   wire [13:0] flag_nxt;
   wire [13:0] flag_set;
   wire [13:0] enable_vec;
   wire [13:0] hw_clr;
   wire [12:0] req_gated;
   wire win_found;
   wire [3:0] win_idx;
   wire [1:0] win_level;
   // Sources whose flag the service hand-off clears
   localparam [13:0] AUTO_MASK = `IRQ_AUTO_MASK;

   // Service tracking, one in-service bit per level
   reg [3:0] isv_r;
   wire [3:0] isv_nxt;
   reg [3:0] top_mask;
   reg [1:0] cur_level;
   wire any_isv;
   wire eligible;
   wire ack_take;
   reg irq_req_r;
   reg [15:0] irq_vector_r;
   reg [1:0] irq_level_r;
   reg [3:0] irq_idx_r;
   reg [15:0] vec_nxt;
   wire [31:0] status_word;

   // ---------------- Bus slave ----------------
   assign addr_phase = hsel & hready & htrans[1];
   assign rd_idx = haddr[11:2];

   // Zero wait states; hreadyout is held low only while reset is applied
   always @(posedge mclk) begin
      if (reset) begin
         wr_pend_r <= 1'b0;
         wr_idx_r <= 10'h000;
         hreadyout_r <= 1'b0;
      end else begin
         wr_pend_r <= addr_phase & hwrite;
         wr_idx_r <= haddr[11:2];
         hreadyout_r <= 1'b1;
      end
   end

   assign wr_en_pri = wr_pend_r && (wr_idx_r == `IRQ_IDX_EN_PRI);
   assign wr_en_sec = wr_pend_r && (wr_idx_r == `IRQ_IDX_EN_SEC);
   assign wr_en_cnv = wr_pend_r && (wr_idx_r == `IRQ_IDX_EN_CNV);
   assign wr_en_pwm = wr_pend_r && (wr_idx_r == `IRQ_IDX_EN_PWM);
   assign wr_prio_lsb = wr_pend_r && (wr_idx_r == `IRQ_IDX_PRIO_LSB);
   assign wr_prio_msb = wr_pend_r && (wr_idx_r == `IRQ_IDX_PRIO_MSB);
   assign wr_pend = wr_pend_r && (wr_idx_r == `IRQ_IDX_PEND);

   // Masks drop writes to reserved positions so they keep reading zero
   assign en_pri_nxt = wr_en_pri ? (hwdata[7:0] & `EN_PRI_WMASK) : en_pri_r;
   assign en_sec_nxt = wr_en_sec ? (hwdata[7:0] & `EN_SEC_WMASK) : en_sec_r;
   assign en_cnv_nxt = wr_en_cnv ? (hwdata[7:0] & `EN_CNV_WMASK) : en_cnv_r;
   assign en_pwm_nxt = wr_en_pwm ? (hwdata[7:0] & `EN_PWM_WMASK) : en_pwm_r;
   assign prio_lsb_nxt = wr_prio_lsb ? (hwdata[7:0] & `PRIO_WMASK) : prio_lsb_r;
   assign prio_msb_nxt = wr_prio_msb ? (hwdata[7:0] & `PRIO_WMASK) : prio_msb_r;

   always @(posedge mclk) begin
      if (reset) begin
         en_pri_r <= `IRQ_RST8;
         en_sec_r <= `IRQ_RST8;
         en_cnv_r <= `IRQ_RST8;
         en_pwm_r <= `IRQ_RST8;
         prio_lsb_r <= `IRQ_RST8;
         prio_msb_r <= `IRQ_RST8;
      end else begin
         en_pri_r <= en_pri_nxt;
         en_sec_r <= en_sec_nxt;
         en_cnv_r <= en_cnv_nxt;
         en_pwm_r <= en_pwm_nxt;
         prio_lsb_r <= prio_lsb_nxt;
         prio_msb_r <= prio_msb_nxt;
      end
   end

   // Status word: in-service bits, a zero, presented level, request, vector
   assign status_word = {8'h00, irq_vector_r, irq_req_r, irq_level_r, 1'b0, isv_r};

   // Read data is taken from next values so a read right behind a write sees it
   always @* begin
      case (rd_idx)
         `IRQ_IDX_EN_PRI: rdata_nxt = {24'h000000, en_pri_nxt};
         `IRQ_IDX_EN_SEC: rdata_nxt = {24'h000000, en_sec_nxt};
         `IRQ_IDX_EN_CNV: rdata_nxt = {24'h000000, en_cnv_nxt};
         `IRQ_IDX_EN_PWM: rdata_nxt = {24'h000000, en_pwm_nxt};
         `IRQ_IDX_PRIO_LSB: rdata_nxt = {24'h000000, prio_lsb_nxt};
         `IRQ_IDX_PRIO_MSB: rdata_nxt = {24'h000000, prio_msb_nxt};
         `IRQ_IDX_PEND: rdata_nxt = {18'h00000, flag_nxt};
         `IRQ_IDX_STAT: rdata_nxt = status_word;
         default: rdata_nxt = 32'h00000000;
      endcase
   end

   // Read data loads in the address phase and stands through the data phase
   always @(posedge mclk) begin
      if (reset) begin
         hrdata_r <= 32'h00000000;
      end else if (addr_phase && !hwrite) begin
         hrdata_r <= rdata_nxt;
      end
   end

   // ---------------- Request flags ----------------
   assign flag_set = {timer2_reload_event, src_event};

   // Enable bits by function, taken from the four enable registers
   assign global_irq_enable = en_pri_r[`EN_PRI_GLOBAL];
   assign timer2_irq_enable = en_pri_r[`EN_PRI_TIMER2];
   assign uart_irq_enable = en_pri_r[`EN_PRI_UART];
   assign timer1_irq_enable = en_pri_r[`EN_PRI_TIMER1];
   assign timer0_irq_enable = en_pri_r[`EN_PRI_TIMER0];
   assign ext_line_irq_enable = en_pri_r[`EN_PRI_EXT];
   assign timer2_reload_irq_enable = en_sec_r[`EN_SEC_RELOAD];
   assign compare3_irq_enable = en_sec_r[`EN_SEC_CMP3];
   assign compare2_irq_enable = en_sec_r[`EN_SEC_CMP2];
   assign compare1_irq_enable = en_sec_r[`EN_SEC_CMP1];
   assign compare0_irq_enable = en_sec_r[`EN_SEC_CMP0];
   assign serial_periph_irq_enable = en_sec_r[`EN_SEC_SPI];
   assign two_wire_irq_enable = en_sec_r[`EN_SEC_TWI];
   assign converter_irq_enable = en_cnv_r[`EN_CNV_ADC];
   assign pulse_gen_irq_enable = en_pwm_r[`EN_PWM_PULSE];

   // Enables in natural order; the reload flag shares the timer 2 source
   assign enable_vec = {timer2_reload_irq_enable, compare3_irq_enable, timer2_irq_enable,
                        compare2_irq_enable, uart_irq_enable, compare1_irq_enable,
                        timer1_irq_enable, compare0_irq_enable, serial_periph_irq_enable,
                        converter_irq_enable, timer0_irq_enable, two_wire_irq_enable,
                        pulse_gen_irq_enable, ext_line_irq_enable};

   genvar g;
   generate
      for (g = 0; g < 14; g = g + 1) begin : flags
         // Only the serviced source loses its flag, and only if it is auto-cleared
         assign hw_clr[g] = ack_take && (irq_idx_r == g) && AUTO_MASK[g];
         irq_request_flag #(
            .AUTO_CLEAR(AUTO_MASK[g])
         ) u_flag (
            .mclk(mclk),
            .reset(reset),
            .set_evt(flag_set[g]),
            .sw_clr(wr_pend & hwdata[g]),
            .hw_clr(hw_clr[g]),
            .flag_nxt(flag_nxt[g]),
            .flag_r(flag_r[g])
         );
      end
   endgenerate

   // A flag requests only while its own enable is set; disabled flags wait
   assign req_gated[10:0] = flag_r[10:0] & enable_vec[10:0];
   // Timer 2 and its reload flag share one request and one vector
   assign req_gated[`IRQ_SRC_TIMER2] = (flag_r[11] & enable_vec[11]) |
                                       (flag_r[`IRQ_FLAG_RELOAD] &
                                        enable_vec[`IRQ_FLAG_RELOAD]);
   assign req_gated[12] = flag_r[12] & enable_vec[12];

   irq_level_arbiter u_arb (
      .req(req_gated),
      .lvl_lsb(prio_lsb_r[5:0]),
      .lvl_msb(prio_msb_r[5:0]),
      .found(win_found),
      .idx(win_idx),
      .level(win_level)
   );

   // ---------------- Service tracking ----------------
   assign any_isv = |isv_r;

   // Most urgent level now in service
   always @* begin
      cur_level = 2'h0;
      if (isv_r[3]) begin
         cur_level = 2'h3;
      end else if (isv_r[2]) begin
         cur_level = 2'h2;
      end else if (isv_r[1]) begin
         cur_level = 2'h1;
      end
   end

   // Return retires the most urgent routine in progress
   always @* begin
      top_mask = 4'h0;
      if (reti && any_isv) begin
         top_mask = 4'h1 << cur_level;
      end
   end

   // Equal or lower level must wait; only a strictly higher level preempts
   assign eligible = win_found && global_irq_enable &&
                     (!any_isv || (win_level > cur_level));
   // A stray accept with no request shown is ignored
   assign ack_take = irq_ack & irq_req_r;
   assign isv_nxt = (isv_r & ~top_mask) | (ack_take ? (4'h1 << irq_level_r) : 4'h0);

   // Vector table in natural order; unused codes give zero
   always @* begin
      case (win_idx)
         4'h0: vec_nxt = `VEC_EXT;
         4'h1: vec_nxt = `VEC_PWM;
         4'h2: vec_nxt = `VEC_TWI;
         4'h3: vec_nxt = `VEC_TIMER0;
         4'h4: vec_nxt = `VEC_ADC;
         4'h5: vec_nxt = `VEC_SPI;
         4'h6: vec_nxt = `VEC_CMP0;
         4'h7: vec_nxt = `VEC_TIMER1;
         4'h8: vec_nxt = `VEC_CMP1;
         4'h9: vec_nxt = `VEC_UART;
         4'hA: vec_nxt = `VEC_CMP2;
         4'hB: vec_nxt = `VEC_TIMER2;
         4'hC: vec_nxt = `VEC_CMP3;
         default: vec_nxt = 16'h0000;
      endcase
   end

   // Request drops for one cycle after an ack so the core never sees a stale vector
   always @(posedge mclk) begin
      if (reset) begin
         isv_r <= `IRQ_RST_ISV;
         irq_req_r <= 1'b0;
         irq_vector_r <= 16'h0000;
         irq_level_r <= 2'h0;
         irq_idx_r <= 4'h0;
      end else begin
         isv_r <= isv_nxt;
         irq_req_r <= eligible & ~ack_take;
         if (!ack_take) begin
            irq_vector_r <= vec_nxt;
            irq_level_r <= win_level;
            irq_idx_r <= win_idx;
         end
      end
   end

   assign hreadyout = hreadyout_r;
   assign hrdata = hrdata_r;
   assign hresp = 1'b0;
   assign irq_req = irq_req_r;
   assign irq_vector = irq_vector_r;
   assign irq_level = irq_level_r;

endmodule

/* gpic_chk.sv */
// Port checker of the grouped priority interrupt controller
`timescale 1ns/100ps
module gpic_chk (
   // Clock and reset
   input wire mclk,
   input wire reset,
   // Bus
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [31:0] hwdata,
   input wire hreadyout,
   input wire [31:0] hrdata,
   input wire hresp,
   // Core
   input wire irq_req,
   input wire [15:0] irq_vector,
   input wire [1:0] irq_level,
   input wire irq_ack,
   input wire reti
);
   logic wr_r;
   logic glb_r;
   logic [3:0] isv_r;
   wire [1:0] top = isv_r[3] ? 2'h3 : isv_r[2] ? 2'h2 : {1'b0, isv_r[1]};
   default clocking @(posedge mclk);
   endclocking
   default disable iff (reset);
   // Mirror of global enable and in-service levels; return retires the highest level
   always @(posedge mclk) begin
      if (reset) begin
         wr_r <= 1'b0;
         glb_r <= 1'b0;
         isv_r <= 4'h0;
      end else begin
         wr_r <= hsel && hreadyout && htrans[1] && hwrite && haddr[11:2] == 10'h0A8;
         if (wr_r)
            glb_r <= hwdata[7];
         // Return and accept in one cycle: retire the old top, then add the new level
         isv_r <= (isv_r & ~((reti && isv_r != 4'h0) ? 4'h1 << top : 4'h0)) |
                  ((irq_req && irq_ack) ? 4'h1 << irq_level : 4'h0);
      end
   end
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("error response seen");
   a_zero_wait: assert property (!$past(reset) |-> hreadyout)
      else $error("wait state inserted");
   a_reset_quiet: assert property ($past(reset) |-> !irq_req && irq_vector == 16'h0000)
      else $error("request right after reset");
   a_vec_range: assert property (irq_req |-> irq_vector[2:0] == 3'h3 && irq_vector <= 16'h008B)
      else $error("vector out of range");
   a_ack_drops: assert property (irq_req && irq_ack |=> !irq_req)
      else $error("request held after accept");
   a_global_off: assert property (!glb_r && !$past(glb_r) |-> !irq_req)
      else $error("request with global enable clear");
   a_preempt_up: assert property (irq_req && isv_r != 4'h0 |-> irq_level > top)
      else $error("request not above running level");
   a_rdata_upper: assert property (hrdata[31:24] == 8'h00)
      else $error("upper read bits set");
   c_service: cover property (irq_req && irq_ack);
   c_nested: cover property (irq_req && isv_r != 4'h0);
   c_global_on: cover property (wr_r && hwdata[7]);
endmodule

bind grouped_priority_interrupt_ctrl gpic_chk i_gpic_chk (.mclk(mclk), .reset(reset),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
   .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq_req(irq_req),
   .irq_vector(irq_vector), .irq_level(irq_level), .irq_ack(irq_ack), .reti(reti));

/* gpic_core_model.sv */
// Behavioural core: accepts a presented vector after a set wait, returns on command
`timescale 1ns/100ps
module gpic_core_model (
   // Clock and reset
   input wire mclk,
   input wire reset,
   // Controller side
   input wire irq_req,
   input wire [15:0] irq_vector,
   input wire [1:0] irq_level,
   output logic irq_ack,
   output logic reti,
   // Bench side
   input wire [3:0] ack_wait,
   input wire ret_cmd,
   output logic [15:0] took_vec,
   output logic [1:0] took_lvl,
   output logic [31:0] took_cnt
);
   logic [3:0] wait_r;
   always @(posedge mclk) begin
      if (reset) begin
         irq_ack <= 1'b0;
         reti <= 1'b0;
         wait_r <= 4'h0;
         took_vec <= 16'h0000;
         took_lvl <= 2'h0;
         took_cnt <= 32'h0;
      end else begin
         irq_ack <= 1'b0;
         reti <= ret_cmd;
         wait_r <= 4'h0;
         if (irq_ack && irq_req) begin
            took_vec <= irq_vector;
            took_lvl <= irq_level;
            took_cnt <= took_cnt + 32'h1;
         end else if (irq_req && !irq_ack) begin
            // Single pulse: a held accept could take a second vector
            if (wait_r >= ack_wait)
               irq_ack <= 1'b1;
            else
               wait_r <= wait_r + 4'h1;
         end
      end
   end
endmodule

/* grouped_priority_interrupt_ctrl_tb_top.sv */
// Self-checking bench of the grouped priority interrupt controller
`timescale 1ns/100ps
module grouped_priority_interrupt_ctrl_tb_top;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic ret_cmd = 1'b0;
   logic trel = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [3:0] ack_wait = 4'h0;
   logic [12:0] src_event = 13'h0000;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
   wire hreadyout, hresp, irq_req, irq_ack, reti;
   wire [1:0] irq_level, took_lvl;
   wire [15:0] irq_vector, took_vec;
   wire [31:0] hrdata, took_cnt;
   int num_errors = 0, total_checks = 0, seen = 0;
   // Byte address and read-back after writing all ones
   logic [31:0] rows [7][2] = '{'{32'h2A0, 32'hBB}, '{32'h2A4, 32'h3F}, '{32'h2E4, 32'h3F},
      '{32'h2E0, 32'hBF}, '{32'h268, 32'h02}, '{32'h26C, 32'h80}, '{32'h3F0, 32'h00}};

   always #2.5 mclk = ~mclk;

   grouped_priority_interrupt_ctrl i_grouped_priority_interrupt_ctrl (.mclk(mclk),
      .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .src_event(src_event), .timer2_reload_event(trel),
      .irq_req(irq_req), .irq_vector(irq_vector), .irq_level(irq_level),
      .irq_ack(irq_ack), .reti(reti));
   gpic_core_model i_gpic_core_model (.mclk(mclk), .reset(reset), .irq_req(irq_req),
      .irq_vector(irq_vector), .irq_level(irq_level), .irq_ack(irq_ack), .reti(reti),
      .ack_wait(ack_wait), .ret_cmd(ret_cmd), .took_vec(took_vec), .took_lvl(took_lvl),
      .took_cnt(took_cnt));

   task automatic chk(input [31:0] e, input [31:0] g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("BAD at %0t exp %h got %h", $time, e, g);
      end
   endtask

   task automatic xfer(input [31:0] a, input w, input [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic pulse(input [12:0] m);
      src_event <= m;
      @(posedge mclk);
      src_event <= 13'h0000;
   endtask

   task automatic take(input [15:0] v, input [1:0] l);
      for (int i = 0; i < 60 && took_cnt == seen; i++) @(posedge mclk);
      seen++;
      chk(seen, took_cnt);
      chk({16'h0, v}, {16'h0, took_vec});
      chk({30'h0, l}, {30'h0, took_lvl});
   endtask

   // No accept may come for eight cycles while a clear enable or the running routine blocks the waiting ones
   task automatic quiet;
      repeat (8) @(posedge mclk);
      chk(seen, took_cnt);
   endtask

   task automatic fin(input [31:0] m);
      if (m != 32'h0)
         xfer(32'h300, 1'b1, m);
      ret_cmd <= 1'b1;
      @(posedge mclk);
      ret_cmd <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask

   task give_verdict;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      for (int k = 0; k < 7; k++) begin
         xfer(rows[k][0], 1'b0, 32'h0);
         chk(32'h0, rd);
         xfer(rows[k][0], 1'b1, 32'hFF);
         xfer(rows[k][0], 1'b0, 32'h0);
         chk(rows[k][1], rd);
         xfer(rows[k][0], 1'b1, 32'h0);
      end
      $display("register test done");
      pulse(13'h0008);
      quiet;
      xfer(32'h300, 1'b0, 32'h0);
      chk(32'h8, rd);
      xfer(32'h300, 1'b1, 32'h8);
      xfer(32'h300, 1'b0, 32'h0);
      chk(32'h8, rd);
      xfer(32'h2A0, 1'b1, 32'h82);
      take(16'h000B, 2'h0);
      fin(32'h0);
      xfer(32'h300, 1'b0, 32'h0);
      chk(32'h0, rd);
      xfer(32'h2A0, 1'b1, 32'h1A);
      pulse(13'h0008);
      quiet;
      xfer(32'h2A0, 1'b1, 32'h9A);
      take(16'h000B, 2'h0);
      fin(32'h0);
      $display("enable test done");
      xfer(32'h2A4, 1'b1, 32'h10);
      xfer(32'h2E4, 1'b1, 32'h10);
      ack_wait <= 4'h5;
      pulse(13'h0288);
      take(16'h0023, 2'h3);
      quiet;
      fin(32'h200);
      take(16'h000B, 2'h0);
      quiet;
      fin(32'h0);
      take(16'h001B, 2'h0);
      fin(32'h0);
      ack_wait <= 4'h0;
      $display("arbitration test done");
      pulse(13'h0080);
      take(16'h001B, 2'h0);
      pulse(13'h0008);
      quiet;
      pulse(13'h0200);
      take(16'h0023, 2'h3);
      xfer(32'h304, 1'b0, 32'h0);
      chk(32'h00002369, rd);
      fin(32'h200);
      quiet;
      fin(32'h0);
      take(16'h000B, 2'h0);
      fin(32'h0);
      $display("preemption test done");
      for (int l = 0; l < 4; l++) begin
         xfer(32'h2A4, 1'b1, l[0] ? 32'h2 : 32'h0);
         xfer(32'h2E4, 1'b1, l[1] ? 32'h2 : 32'h0);
         pulse(13'h0008);
         take(16'h000B, l[1:0]);
         fin(32'h0);
      end
      $display("level test done");
      xfer(32'h2E0, 1'b1, 32'h80);
      trel <= 1'b1;
      @(posedge mclk);
      trel <= 1'b0;
      take(16'h002B, 2'h0);
      fin(32'h2000);
      xfer(32'h300, 1'b0, 32'h0);
      chk(32'h0, rd);
      $display("reload test done");
      pulse(13'h0002);
      reset <= 1'b1;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      xfer(32'h300, 1'b0, 32'h0);
      chk(32'h0, rd);
      xfer(32'h2A0, 1'b0, 32'h0);
      chk(32'h0, rd);
      $display("reset test done");
      give_verdict;
   end

   // Tests need a few hundred cycles; twenty thousand marks a hang
   initial begin
      #100000;
      num_errors++;
      give_verdict;
   end
endmodule
